// File: hw/spcs_core.sv
// Command and status core of the fieldbus scanner facing the PLC CPU.
// All inputs come from logic on clk; none need synchronising.
//
// Behaviour
// - Explicit option selects extended or standard layout.
// - Layout sizes: 8/0/8/4 or 8/4/16/4.
// - No traffic before scan list; poll listed only.
// - Each node holds reference and size per type.
// - Send expected packet rate; node times out after fixed 2000 ns.
// - Stop bit releases connections, halts polling; sends still start.
// - Scan stopped flag while stop bit set.
// - Send bit starts one explicit transaction.
// - Done flag then error flags in bits 3-13.
// - Output words: tx start, tx len, rx start, rx len.
// - Separate flag for each explicit error cause.
// - Any-offline bit plus four per-node online words.
// - Reference address starts node's contiguous block.
// - Node zero at LSB of first online word.
// - Online only while polled connection exchanges data.
`timescale 1ns/100ps
`include "spcs_regs.svh"

module spcs_core
    import spcs_pkg::*;
(
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    ce,
    // Module configuration
    input  wire logic                    cfgExplicitEn,
    input  wire logic                    cfgWrEn,
    input  wire logic [`SPCS_NODE_W-1:0] cfgNode,
    input  wire logic [3:0]              cfgField,
    input  wire spcs_word_t              cfgData,
    input  wire logic                    cfgScanListLoad,
    // PLC output registers
    input  wire logic                    plcWrEn,
    input  wire logic [2:0]              plcWrSel,
    input  wire spcs_word_t              plcWrData,
    output logic [7:0]                   commandBits_ff,
    output spcs_word_t                   txBufferStart_ff,
    output spcs_word_t                   txLength_ff,
    output spcs_word_t                   rxBufferStart_ff,
    output spcs_word_t                   rxLength_ff,
    // PLC input registers
    output spcs_word_t                   statusFlags_ff,
    output spcs_word_t                   onlineWordFirst,
    output spcs_word_t                   onlineWordSecond,
    output spcs_word_t                   onlineWordThird,
    output spcs_word_t                   onlineWordHigh,
    // Assembly sizes
    output logic [2:0]                   layoutOutWords_ff,
    output logic [4:0]                   layoutInBits_ff,
    output logic [4:0]                   layoutCmdBits_ff,
    output logic [2:0]                   layoutStatWords_ff,
    // Polled network side
    output logic                         pollReq_ff,
    output logic [`SPCS_NODE_W-1:0]      pollNode_ff,
    output spcs_word_t                   pollEpr_ff,
    output logic                         releaseAll_ff,
    input  wire logic                    pollAck,
    input  wire logic                    pollEstablished,
    // Register placement of polled data
    input  wire spcs_map_t               mapType,
    input  wire spcs_word_t              mapIndex,
    output spcs_word_t                   mapAddr_ff,
    output logic                         mapValid_ff,
    // Explicit message engine
    output logic                         explicitStart_ff,
    input  wire logic                    explicitDone,
    input  wire logic [`SPCS_ERR_N-1:0]  explicitErr
);
    // Configuration state
    logic                      explicitMode_ff;
    logic                      nxt_explicitMode;
    logic                      listLoaded_ff;
    logic                      nxt_listLoaded;

    // Node table lookups
    spcs_word_t                tblRef;
    spcs_word_t                tblSize;
    spcs_word_t                tblEpr;
    logic [`SPCS_NODES-1:0]    inScanVec;

    // PLC command state
    logic [7:0]                nxt_commandBits;
    spcs_word_t                nxt_txBufferStart;
    spcs_word_t                nxt_txLength;
    spcs_word_t                nxt_rxBufferStart;
    spcs_word_t                nxt_rxLength;

    // Scan state
    spcs_scan_t                scan_ff;
    spcs_scan_t                nxt_scan;
    logic [`SPCS_NODE_W-1:0]   nxt_pollNode;
    logic [15:0]               pollTmr_ff;
    logic [15:0]               nxt_pollTmr;
    logic [`SPCS_NODES-1:0]    online_ff;
    logic [`SPCS_NODES-1:0]    nxt_online;
    logic                      nxt_pollReq;
    spcs_word_t                nxt_pollEpr;
    logic                      nxt_releaseAll;

    // Explicit state
    spcs_ex_t                  ex_ff;
    spcs_ex_t                  nxt_ex;
    logic                      sendPrev_ff;
    logic                      exDone_ff;
    logic                      nxt_exDone;
    logic [`SPCS_ERR_N-1:0]    exErr_ff;
    logic [`SPCS_ERR_N-1:0]    nxt_exErr;
    logic [15:0]               exTmr_ff;
    logic [15:0]               nxt_exTmr;
    logic                      nxt_explicitStart;

    // Output registers
    spcs_word_t                nxt_statusFlags;
    spcs_word_t                nxt_mapAddr;
    logic                      nxt_mapValid;
    logic [2:0]                nxt_layoutOutWords;
    logic [4:0]                nxt_layoutInBits;

    logic                      stopCmd;
    logic                      sendRise;

    // Range check used for placement of node data
    function automatic logic inBlock(input spcs_word_t idx,
                                     input spcs_word_t size);
        inBlock = (idx < size);
    endfunction

    spcs_node_table u_table (
        .clk       (clk),
        .rst_n     (rst_n),
        .ce        (ce),
        .wrEn      (cfgWrEn),
        .wrNode    (cfgNode),
        .wrField   (cfgField),
        .wrData    (cfgData),
        .rdNode    (pollNode_ff),
        .rdType    (mapType),
        .rdRef     (tblRef),
        .rdSize    (tblSize),
        .rdEpr     (tblEpr),
        .inScanVec (inScanVec)
    );

    assign stopCmd  = commandBits_ff[`SPCS_CMD_STOP];
    assign sendRise = commandBits_ff[`SPCS_CMD_SEND] & ~sendPrev_ff;

    // Configuration and PLC command registers
    always_comb begin
        nxt_explicitMode  = explicitMode_ff;
        nxt_listLoaded    = listLoaded_ff;
        nxt_commandBits   = commandBits_ff;
        nxt_txBufferStart = txBufferStart_ff;
        nxt_txLength      = txLength_ff;
        nxt_rxBufferStart = rxBufferStart_ff;
        nxt_rxLength      = rxLength_ff;
        if (cfgScanListLoad) begin
            nxt_explicitMode = cfgExplicitEn;
            nxt_listLoaded   = 1'b1;
        end
        if (plcWrEn) begin
            case (plcWrSel)
                `SPCS_SEL_CMD: begin
                    // Bits 2-7 stored but never acted upon
                    nxt_commandBits = plcWrData[7:0];
                end
                `SPCS_SEL_TXSTART: begin
                    nxt_txBufferStart = plcWrData;
                end
                `SPCS_SEL_TXLEN: begin
                    nxt_txLength = plcWrData;
                end
                `SPCS_SEL_RXSTART: begin
                    nxt_rxBufferStart = plcWrData;
                end
                `SPCS_SEL_RXLEN: begin
                    nxt_rxLength = plcWrData;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            explicitMode_ff  <= 1'b0;
            listLoaded_ff    <= 1'b0;
            commandBits_ff   <= 8'h00;
            txBufferStart_ff <= 16'h0000;
            txLength_ff      <= 16'h0000;
            rxBufferStart_ff <= 16'h0000;
            rxLength_ff      <= 16'h0000;
        end else if (ce) begin
            explicitMode_ff  <= nxt_explicitMode;
            listLoaded_ff    <= nxt_listLoaded;
            commandBits_ff   <= nxt_commandBits;
            txBufferStart_ff <= nxt_txBufferStart;
            txLength_ff      <= nxt_txLength;
            rxBufferStart_ff <= nxt_rxBufferStart;
            rxLength_ff      <= nxt_rxLength;
        end
    end

    // Scan sequencer
    always_comb begin
        nxt_scan       = scan_ff;
        nxt_pollNode   = pollNode_ff;
        nxt_pollTmr    = pollTmr_ff;
        nxt_online     = online_ff & inScanVec;
        nxt_pollReq    = 1'b0;
        nxt_pollEpr    = pollEpr_ff;
        nxt_releaseAll = 1'b0;
        if (stopCmd && scan_ff != SC_STOP) begin
            // Drop every connection in one step
            nxt_scan       = SC_STOP;
            nxt_releaseAll = 1'b1;
            nxt_online     = '0;
        end else begin
            case (scan_ff)
                SC_NOLIST: begin
                    if (listLoaded_ff) begin
                        nxt_scan     = SC_POLL;
                        nxt_pollNode = '0;
                    end
                end
                SC_POLL: begin
                    if (inScanVec[pollNode_ff]) begin
                        nxt_pollReq = 1'b1;
                        nxt_pollEpr = tblEpr;
                        nxt_pollTmr = 16'(`SPCS_POLL_WAIT_CYC);
                        nxt_scan    = SC_WAIT;
                    end else begin
                        nxt_online[pollNode_ff] = 1'b0;
                        nxt_pollNode = pollNode_ff + 1'b1;
                    end
                end
                SC_WAIT: begin
                    if (pollAck) begin
                        nxt_online[pollNode_ff] = pollEstablished;
                        nxt_pollNode = pollNode_ff + 1'b1;
                        nxt_scan     = SC_POLL;
                    end else if (pollTmr_ff == 16'h0000) begin
                        // Silent node counts as offline
                        nxt_online[pollNode_ff] = 1'b0;
                        nxt_pollNode = pollNode_ff + 1'b1;
                        nxt_scan     = SC_POLL;
                    end else begin
                        nxt_pollTmr = pollTmr_ff - 1'b1;
                    end
                end
                SC_STOP: begin
                    nxt_online = '0;
                    if (!stopCmd) begin
                        nxt_scan     = listLoaded_ff ? SC_POLL : SC_NOLIST;
                        nxt_pollNode = '0;
                    end
                end
                default: begin
                    nxt_scan = SC_NOLIST;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scan_ff       <= SC_NOLIST;
            pollNode_ff   <= '0;
            pollTmr_ff    <= 16'h0000;
            online_ff     <= '0;
            pollReq_ff    <= 1'b0;
            pollEpr_ff    <= 16'h0000;
            releaseAll_ff <= 1'b0;
        end else if (ce) begin
            scan_ff       <= nxt_scan;
            pollNode_ff   <= nxt_pollNode;
            pollTmr_ff    <= nxt_pollTmr;
            online_ff     <= nxt_online;
            pollReq_ff    <= nxt_pollReq;
            pollEpr_ff    <= nxt_pollEpr;
            releaseAll_ff <= nxt_releaseAll;
        end
    end

    // Explicit transaction tracking
    always_comb begin
        nxt_ex            = ex_ff;
        nxt_exDone        = exDone_ff;
        nxt_exErr         = exErr_ff;
        nxt_exTmr         = exTmr_ff;
        nxt_explicitStart = 1'b0;
        case (ex_ff)
            EX_IDLE: begin
                // Sends while busy are dropped, one at a time
                if (sendRise && explicitMode_ff) begin
                    nxt_explicitStart = 1'b1;
                    nxt_exDone        = 1'b0;
                    nxt_exErr         = '0;
                    nxt_exTmr         = 16'(`SPCS_EX_TMO_CYC);
                    nxt_ex            = EX_BUSY;
                end
            end
            EX_BUSY: begin
                if (explicitDone) begin
                    nxt_exDone = 1'b1;
                    nxt_exErr  = explicitErr;
                    nxt_ex     = EX_IDLE;
                end else if (exTmr_ff == 16'h0000) begin
                    nxt_exDone = 1'b1;
                    nxt_exErr[`SPCS_ST_ERR_TMO-`SPCS_ST_ERR_LO] = 1'b1;
                    nxt_ex     = EX_IDLE;
                end else begin
                    nxt_exTmr = exTmr_ff - 1'b1;
                end
            end
            default: begin
                nxt_ex = EX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ex_ff            <= EX_IDLE;
            sendPrev_ff      <= 1'b0;
            exDone_ff        <= 1'b0;
            exErr_ff         <= '0;
            exTmr_ff         <= 16'h0000;
            explicitStart_ff <= 1'b0;
        end else if (ce) begin
            ex_ff            <= nxt_ex;
            sendPrev_ff      <= commandBits_ff[`SPCS_CMD_SEND];
            exDone_ff        <= nxt_exDone;
            exErr_ff         <= nxt_exErr;
            exTmr_ff         <= nxt_exTmr;
            explicitStart_ff <= nxt_explicitStart;
        end
    end

    // Status word, layout sizes and data placement
    always_comb begin
        nxt_statusFlags = 16'h0000;
        nxt_statusFlags[`SPCS_ST_OFFLINE] =
            |(inScanVec & ~online_ff);
        nxt_statusFlags[`SPCS_ST_STOPPED] = (scan_ff == SC_STOP);
        // Standard layout shows only the offline and stopped bits
        if (explicitMode_ff) begin
            nxt_statusFlags[`SPCS_ST_DONE] = exDone_ff;
            nxt_statusFlags[`SPCS_ST_ERR_HI:`SPCS_ST_ERR_LO] =
                exErr_ff;
            nxt_layoutOutWords = `SPCS_AQ_WORDS_EXT;
            nxt_layoutInBits   = `SPCS_I_BITS_EXT;
        end else begin
            nxt_layoutOutWords = `SPCS_AQ_WORDS_STD;
            nxt_layoutInBits   = `SPCS_I_BITS_STD;
        end
        // Node data is a contiguous block from its reference
        nxt_mapValid = inScanVec[pollNode_ff] &&
                       inBlock(mapIndex, tblSize);
        nxt_mapAddr  = nxt_mapValid ? tblRef + mapIndex
                                    : 16'h0000;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            statusFlags_ff     <= 16'h0000;
            layoutOutWords_ff  <= `SPCS_AQ_WORDS_STD;
            layoutInBits_ff    <= `SPCS_I_BITS_STD;
            layoutCmdBits_ff   <= `SPCS_Q_BITS;
            layoutStatWords_ff <= `SPCS_AI_WORDS;
            mapAddr_ff         <= 16'h0000;
            mapValid_ff        <= 1'b0;
        end else if (ce) begin
            statusFlags_ff     <= nxt_statusFlags;
            layoutOutWords_ff  <= nxt_layoutOutWords;
            layoutInBits_ff    <= nxt_layoutInBits;
            layoutCmdBits_ff   <= `SPCS_Q_BITS;
            layoutStatWords_ff <= `SPCS_AI_WORDS;
            mapAddr_ff         <= nxt_mapAddr;
            mapValid_ff        <= nxt_mapValid;
        end
    end

    // Node n sits at bit n, sixteen nodes per word
    assign onlineWordFirst  = online_ff[15:0];
    assign onlineWordSecond = online_ff[31:16];
    assign onlineWordThird  = online_ff[47:32];
    assign onlineWordHigh   = online_ff[63:48];
endmodule

// File: hw/spcs_regs.svh
// Constants of the command and status block.
// Included by the package and design files.
`ifndef SPCS_REGS_SVH
`define SPCS_REGS_SVH

`define SPCS_NODES          64
`define SPCS_NODE_W         6
`define SPCS_CLK_MHZ        250

// Assembly sizes per layout
`define SPCS_Q_BITS         5'h08
`define SPCS_AQ_WORDS_STD   3'h0
`define SPCS_AQ_WORDS_EXT   3'h4
`define SPCS_I_BITS_STD     5'h08
`define SPCS_I_BITS_EXT     5'h10
`define SPCS_AI_WORDS       3'h4

// Command bit positions
`define SPCS_CMD_STOP       0
`define SPCS_CMD_SEND       1

// Status bit positions
`define SPCS_ST_OFFLINE     0
`define SPCS_ST_STOPPED     1
`define SPCS_ST_DONE        2
`define SPCS_ST_ERR_LO      3
`define SPCS_ST_ERR_HI      13
`define SPCS_ST_ERR_TMO     9
`define SPCS_ERR_N          11

// PLC write selects
`define SPCS_SEL_CMD        3'h0
`define SPCS_SEL_TXSTART    3'h1
`define SPCS_SEL_TXLEN      3'h2
`define SPCS_SEL_RXSTART    3'h3
`define SPCS_SEL_RXLEN      3'h4

// Node table fields
`define SPCS_FLD_INSCAN     4'h0
`define SPCS_FLD_IREF       4'h1
`define SPCS_FLD_ISIZE      4'h2
`define SPCS_FLD_AIREF      4'h3
`define SPCS_FLD_AISIZE     4'h4
`define SPCS_FLD_QREF       4'h5
`define SPCS_FLD_QSIZE      4'h6
`define SPCS_FLD_AQREF      4'h7
`define SPCS_FLD_AQSIZE     4'h8
`define SPCS_FLD_EPR        4'h9
`define SPCS_FLD_N          10

// Timing
`define SPCS_POLL_WAIT_NS   2000
`define SPCS_POLL_WAIT_CYC  ((`SPCS_POLL_WAIT_NS * `SPCS_CLK_MHZ) / 1000)
`define SPCS_EX_TMO_NS      16000
`define SPCS_EX_TMO_CYC     ((`SPCS_EX_TMO_NS * `SPCS_CLK_MHZ) / 1000)

`endif

// File: hw/spcs_pkg.sv
// Types for the scanner PLC command and status block.
// Includes spcs_regs.svh but uses none of its constants.
`include "spcs_regs.svh"

package spcs_pkg;
    typedef logic [15:0] spcs_word_t;

    typedef enum logic [1:0] {
        SC_NOLIST = 2'b00,
        SC_POLL   = 2'b01,
        SC_WAIT   = 2'b10,
        SC_STOP   = 2'b11
    } spcs_scan_t;

    typedef enum logic [0:0] {
        EX_IDLE = 1'b0,
        EX_BUSY = 1'b1
    } spcs_ex_t;

    typedef enum logic [1:0] {
        MT_I  = 2'b00,
        MT_AI = 2'b01,
        MT_Q  = 2'b10,
        MT_AQ = 2'b11
    } spcs_map_t;
endpackage

// File: hw/spcs_node_table.sv
// Per-node scan list, register mapping and packet rate storage.
// Same clock as the core; written from the configuration port.
`timescale 1ns/100ps
`include "spcs_regs.svh"

module spcs_node_table
    import spcs_pkg::*;
(
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    ce,
    // Configuration write
    input  wire logic                    wrEn,
    input  wire logic [`SPCS_NODE_W-1:0] wrNode,
    input  wire logic [3:0]              wrField,
    input  wire spcs_word_t              wrData,
    // Lookup
    input  wire logic [`SPCS_NODE_W-1:0] rdNode,
    input  wire spcs_map_t               rdType,
    output spcs_word_t                   rdRef,
    output spcs_word_t                   rdSize,
    output spcs_word_t                   rdEpr,
    output logic [`SPCS_NODES-1:0]       inScanVec
);
    spcs_word_t                tbl_ff [`SPCS_NODES][`SPCS_FLD_N];
    spcs_word_t                nxt_tbl [`SPCS_NODES][`SPCS_FLD_N];
    logic [`SPCS_NODES-1:0]    inScan_ff;
    logic [`SPCS_NODES-1:0]    nxt_inScan;

    always_comb begin
        nxt_tbl    = tbl_ff;
        nxt_inScan = inScan_ff;
        if (wrEn) begin
            if (wrField == `SPCS_FLD_INSCAN) begin
                nxt_inScan[wrNode] = wrData[0];
            end else if (wrField < 4'(`SPCS_FLD_N)) begin
                nxt_tbl[wrNode][wrField] = wrData;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            inScan_ff <= '0;
            for (int n = 0; n < `SPCS_NODES; n++) begin
                for (int f = 0; f < `SPCS_FLD_N; f++) begin
                    tbl_ff[n][f] <= 16'h0000;
                end
            end
        end else if (ce) begin
            inScan_ff <= nxt_inScan;
            tbl_ff    <= nxt_tbl;
        end
    end

    always_comb begin
        case (rdType)
            MT_I: begin
                rdRef  = tbl_ff[rdNode][`SPCS_FLD_IREF];
                rdSize = tbl_ff[rdNode][`SPCS_FLD_ISIZE];
            end
            MT_AI: begin
                rdRef  = tbl_ff[rdNode][`SPCS_FLD_AIREF];
                rdSize = tbl_ff[rdNode][`SPCS_FLD_AISIZE];
            end
            MT_Q: begin
                rdRef  = tbl_ff[rdNode][`SPCS_FLD_QREF];
                rdSize = tbl_ff[rdNode][`SPCS_FLD_QSIZE];
            end
            default: begin
                rdRef  = tbl_ff[rdNode][`SPCS_FLD_AQREF];
                rdSize = tbl_ff[rdNode][`SPCS_FLD_AQSIZE];
            end
        endcase
    end

    assign rdEpr     = tbl_ff[rdNode][`SPCS_FLD_EPR];
    assign inScanVec = inScan_ff;
endmodule

// File: verification/spcs_core_chk.sv
// Port assertions for the command and status core.
// Bound into it; assumes ce stays high.
`timescale 1ns/100ps
module spcs_core_chk
    import spcs_pkg::*;
(
    input wire logic         clk, rst_n, cfgScanListLoad, pollReq_ff,
    input wire logic         releaseAll_ff, pollAck, pollEstablished,
    input wire logic         explicitStart_ff, explicitDone,
    input wire logic [7:0]   commandBits_ff,
    input wire logic [5:0]   pollNode_ff,
    input wire logic [2:0]   layoutOutWords_ff,
    input wire logic [4:0]   layoutInBits_ff,
    input wire logic [10:0]  explicitErr,
    input wire spcs_word_t   statusFlags_ff, onlineWordFirst,
    input wire spcs_word_t   onlineWordSecond, onlineWordThird, onlineWordHigh
);
    logic        listed_ff, busy_ff, nxt_listed, nxt_busy;
    logic [63:0] onVec;
    // A timed-out send leaves busy set
    always_comb begin
        nxt_listed = rst_n & (listed_ff | cfgScanListLoad);
        nxt_busy = rst_n & (explicitStart_ff | (busy_ff & !explicitDone));
        onVec = {onlineWordHigh, onlineWordThird, onlineWordSecond,
                 onlineWordFirst};
    end
    always_ff @(posedge clk) begin
        listed_ff <= nxt_listed;
        busy_ff <= nxt_busy;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_poll;
        pollReq_ff ##1 (pollAck && pollEstablished && !commandBits_ff[0]);
    endsequence
    sequence s_stop;
        commandBits_ff[0] [*3];
    endsequence
    property p_lay;
        (layoutInBits_ff == 5'h10 && layoutOutWords_ff == 3'h4) ||
        (layoutInBits_ff == 5'h08 && layoutOutWords_ff == 3'h0);
    endproperty
    property p_ext;
        explicitStart_ff |-> layoutInBits_ff == 5'h10;
    endproperty
    property p_start;
        explicitStart_ff |-> $past(commandBits_ff[1]) &&
                             !$past(commandBits_ff[1], 2);
    endproperty
    property p_clr;
        explicitStart_ff |=> statusFlags_ff[13:2] == 12'h000;
    endproperty
    property p_done;
        busy_ff && explicitDone |-> ##2 statusFlags_ff[2] &&
            statusFlags_ff[13:3] == $past(explicitErr, 2);
    endproperty
    property p_stop;
        s_stop |-> statusFlags_ff[1] && !pollReq_ff && onVec == 64'h0;
    endproperty
    property p_rel;
        $rose(commandBits_ff[0]) |=> releaseAll_ff;
    endproperty
    property p_online;
        s_poll |=> onVec[$past(pollNode_ff, 2)];
    endproperty
    property p_list;
        pollReq_ff |-> listed_ff;
    endproperty
    a_lay: assert property (p_lay) else $error("bad layout");
    a_ext: assert property (p_ext) else $error("send in std");
    a_start: assert property (p_start) else $error("start w/o rise");
    a_clr: assert property (p_clr) else $error("stale flags");
    a_done: assert property (p_done) else $error("bad done");
    a_stop: assert property (p_stop) else $error("stop not held");
    a_rel: assert property (p_rel) else $error("no release");
    a_online: assert property (p_online) else $error("online bit");
    a_list: assert property (p_list) else $error("early poll");
endmodule
bind spcs_core spcs_core_chk spcs_core_chk_inst (.*);

// File: verification/spcs_node_model.sv
// Node-side stand-in answering polls and sends.
// Poll answers alternate prompt and slow, sends follow the last poll; mute stops them.
`timescale 1ns/100ps
module spcs_node_model (
    input  wire logic        clk,
    input  wire logic        pollReq_ff,
    input  wire logic        explicitStart_ff,
    input  wire logic        mute,
    input  wire logic [10:0] errIn,
    output logic             pollAck = 0,
    output logic             pollEstablished = 0,
    output logic             explicitDone = 0,
    output logic [10:0]      explicitErr = 0
);
    int pc = -1, ec = -1;
    bit alt = 0;
    // Idle established and error lines toggle so stale values fail
    always @(posedge clk) begin
        if (pollReq_ff) alt = !alt;
        pc = (pollReq_ff && !mute) ? (alt ? 7 : 0) : pc - 1;
        ec = (explicitStart_ff && !mute) ? (alt ? 9 : 2) : ec - 1;
        pollAck <= #1 (pc == 0);
        pollEstablished <= #1 (pc == 0) ? 1'b1 : !pollEstablished;
        explicitDone <= #1 (ec == 0);
        explicitErr <= #1 (ec == 0) ? errIn : ~explicitErr;
    end
endmodule

// File: verification/spcs_core_tb_top.sv
// Bench for the command and status core.
// Assumes the node model answers its polls.
`timescale 1ns/100ps
`include "spcs_regs.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fail_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module spcs_core_tb_top
    import spcs_pkg::*;
;
    logic clk = 0, rst_n = 0, ce = 1, cfgExplicitEn = 0, cfgWrEn = 0;
    logic cfgScanListLoad = 0, plcWrEn = 0, mute = 0, pollAck;
    logic pollEstablished, explicitDone, pollReq_ff, releaseAll_ff;
    logic mapValid_ff, explicitStart_ff;
    logic [5:0] cfgNode = 0, pollNode_ff;
    logic [5:0] lst [3] = '{6'h00, 6'h11, 6'h3F};
    logic [3:0] cfgField = 0;
    logic [2:0] plcWrSel = 0, layoutOutWords_ff, layoutStatWords_ff;
    logic [4:0] layoutInBits_ff, layoutCmdBits_ff;
    logic [7:0] commandBits_ff;
    logic [10:0] explicitErr, errIn = 0;
    spcs_word_t cfgData = 0, plcWrData = 0, mapIndex = 0, mapAddr_ff;
    spcs_word_t txBufferStart_ff, txLength_ff, rxBufferStart_ff, rxLength_ff;
    spcs_word_t statusFlags_ff, onlineWordFirst, onlineWordSecond, pollEpr_ff;
    spcs_word_t onlineWordThird, onlineWordHigh;
    spcs_map_t mapType = MT_I;
    int fail_count = 0, num_checks = 0;
    wire [15:0] lay = {layoutCmdBits_ff, layoutStatWords_ff,
        layoutInBits_ff, layoutOutWords_ff};
    always #2 clk = ~clk;
    spcs_core spcs_core_inst (.*);
    spcs_node_model spcs_node_model_inst (.*);
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task plc(input logic [2:0] s, input spcs_word_t d);
        tick(1);
        {plcWrEn, plcWrSel, plcWrData} = {1'b1, s, d};
        tick(1);
        plcWrEn = 0;
    endtask
    task cfg(input logic [5:0] n, input logic [3:0] f,
             input spcs_word_t d);
        tick(1);
        {cfgWrEn, cfgNode, cfgField, cfgData} = {1'b1, n, f, d};
        tick(1);
        cfgWrEn = 0;
    endtask
    task boot(input logic x);
        rst_n = 0;
        cfgExplicitEn = x;
        tick(3);
        `CHK({lay, statusFlags_ff}, 32'h4440_0000)
        rst_n = 1;
        cfg(6'h00, `SPCS_FLD_IREF, 16'h0100);
        cfg(6'h00, `SPCS_FLD_ISIZE, 16'h0004);
        cfg(6'h00, `SPCS_FLD_EPR, 16'h0032);
        foreach (lst[k]) cfg(lst[k], `SPCS_FLD_INSCAN, 16'h0001);
        cfgScanListLoad = 1;
        tick(1);
        cfgScanListLoad = 0;
        tick(4);
    endtask
    task close_out;
        $display("checks=%0d errors=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        boot(1'b0);
        `CHK(statusFlags_ff[0], 1'b1)
        for (int s = 1; s < 6; s++) plc(3'(s), 16'(16'h1111 * s));
        `CHK({txBufferStart_ff, txLength_ff}, 32'h1111_2222)
        `CHK({rxBufferStart_ff, rxLength_ff}, 32'h3333_4444)
        plc(3'h0, 16'h0002);
        tick(10);
        `CHK(statusFlags_ff[13:2], 12'h000)
        plc(3'h0, 16'h0000);
        tick(400);
        `CHK({onlineWordHigh, onlineWordThird}, 32'h8000_0000)
        `CHK({onlineWordSecond, onlineWordFirst}, 32'h0002_0001)
        `CHK(statusFlags_ff[1:0], 2'b00)
        plc(3'h0, 16'h0001);
        tick(2);
        `CHK({statusFlags_ff[1:0], onlineWordFirst}, 18'h3_0000)
        tick(600);
        `CHK(statusFlags_ff[1], 1'b1)
        mute = 1;
        plc(3'h0, 16'h0000);
        for (int i = 0; i < 50 && pollReq_ff !== 1'b1; i++) tick(1);
        `CHK({pollNode_ff, pollEpr_ff}, 22'h00_0032)
        mapIndex = 16'h0003;
        tick(2);
        `CHK({mapValid_ff, mapAddr_ff}, 17'h1_0103)
        mapIndex = 16'h0004;
        tick(2);
        `CHK({mapValid_ff, mapAddr_ff}, 17'h0_0000)
        mute = 0;
        boot(1'b1);
        `CHK(lay, 16'h4484)
        for (int i = 0; i < 11; i++) begin
            errIn = 11'h001 << i;
            plc(3'h0, 16'h0002);
            tick(20);
            `CHK(statusFlags_ff[13:2], {errIn, 1'b1})
            plc(3'h0, 16'h0000);
        end
        mute = 1;
        plc(3'h0, 16'h0002);
        tick(4010);
        `CHK(statusFlags_ff[13:2], 12'h081)
        close_out;
    end
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        close_out;
    end
endmodule
